// >>> hw/mt_pkg.sv
// Package with register map, field layout and enumerations of the timer
package mt_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [3:0] STATUS_CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] CLOCK_CONFIG_OFFSET   = 4'h4;
    localparam logic [3:0] COUNT_VALUE_OFFSET    = 4'h8;
    localparam logic [3:0] MODULO_LIMIT_OFFSET   = 4'hc;
    localparam int         ADDR_WIDTH            = 4;

    // Field positions in the status and control register
    localparam int OVERFLOW_FLAG_BIT    = 7;
    localparam int OVERFLOW_IRQ_EN_BIT  = 6;
    localparam int COUNTER_CLEAR_BIT    = 5;
    localparam int COUNTER_HALT_BIT     = 4;

    // Field positions in the clock configuration register
    localparam int CLOCK_SELECT_LSB     = 4;
    localparam int PRESCALE_LSB         = 0;

    // Reset values and limits
    localparam logic [7:0] COUNT_RESET_VALUE  = 8'h00;
    localparam logic [7:0] MODULO_RESET_VALUE = 8'h00;
    localparam logic [1:0] CLOCK_SELECT_RESET = 2'h0;
    localparam logic [3:0] PRESCALE_RESET     = 4'h0;
    localparam logic [3:0] PRESCALE_MAX_CODE  = 4'h8;
    localparam logic [7:0] COUNT_FULL_VALUE   = 8'hff;

    // AXI response codes
    localparam logic [1:0] AXI_RESP_OKAY   = 2'h0;
    localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

    // Clock source encodings
    typedef enum logic [1:0] {
        MT_SRC_BUS       = 2'b00,
        MT_SRC_FIXED     = 2'b01,
        MT_SRC_PIN_FALL  = 2'b10,
        MT_SRC_PIN_RISE  = 2'b11
    } mt_source_type;

    // Power and debug state of the processor seen by the timer
    typedef struct packed {
        logic wait_mode;
        logic stop_mode;
        logic deep_stop_wake;
        logic stop_reset_exit;
        logic debug_active;
    } mt_power_type;

endpackage

// >>> hw/mt_timer.sv
// Modulo timer: 8-bit up-counter with prescaler and AXI4-Lite registers
// Function
// R1 - 8-bit up-counter, free-running or modulo wrap
// R2 - Software-enabled interrupt on counter overflow
// R3 - Four selectable prescaler input sources
// R4 - Prescaler divides by one through 256
// R5 - Upper clock-select codes pick external pin
// R6 - Pin may also feed the companion timer
// R7 - Synchronise external pin to bus clock
// R8 - Pin frequency at most quarter bus clock
// R9 - Keeps running in wait, can wake
// R10 - Software halts timer before wait if unused
// R11 - Timer disabled in every stop mode
// R12 - Reset state after deep stop or reset
// R13 - Light stop interrupt exit keeps state
// R14 - Counting suspended during background debug
// R15 - Resume after debug unless cleared meanwhile
// R16 - Four 8-bit software registers
// R17 - Counter-clear control zeroes the count
// R18 - Halt bit freezes counter while set
// R19 - Overflow flag set and clear conditions
// R20 - Clock-select encoding, unused codes use bus
// R21 - Prescale codes above eight divide by 256
// R22 - Reset sets halt, clears interrupt enable
// R23 - Interrupt when flag and enable set
module mt_timer
    import mt_pkg::*;
#(
    parameter int COUNT_WIDTH = 8
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  resetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output      logic                  s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output      logic                  s_axi_wready,
    // AXI4-Lite write response
    output      logic [1:0]            s_axi_bresp,
    output      logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output      logic                  s_axi_arready,
    // AXI4-Lite read data
    output      logic [31:0]           s_axi_rdata,
    output      logic [1:0]            s_axi_rresp,
    output      logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Clock sources and pin
    input  wire logic                  fixed_freq_clock,
    input  wire logic                  ext_timer_clock_pin,
    // Processor mode
    input  wire mt_power_type          power_state,
    // Interrupt request
    output      logic                  overflow_irq
);

    // Register state
    logic [COUNT_WIDTH-1:0] count_reg;         // Current count
    logic [COUNT_WIDTH-1:0] modulo_reg;        // Modulo limit
    logic                   flag_reg;          // Overflow flag
    logic                   irq_enable_reg;    // Overflow interrupt enable
    logic                   halt_reg;          // Counter halt bit
    logic [1:0]             clock_select_reg;  // Clock source select
    logic [3:0]             prescale_reg;      // Prescale select
    logic                   flag_seen_reg;     // Flag read while set
    logic [7:0]             prescaler_reg;     // Prescaler counter

    // Synchronisers for the pin and the fixed-frequency clock
    logic [1:0] pin_sync_reg;                  // Pin two-stage sync
    logic       pin_last_reg;                  // Previous synced pin
    logic [1:0] fixed_sync_reg;                // Fixed clock sync
    logic       fixed_last_reg;                // Previous synced fixed

    // Bus handshake state
    logic                  aw_held_reg;        // Write address captured
    logic                  w_held_reg;         // Write data captured
    logic [ADDR_WIDTH-1:0] awaddr_reg;         // Captured write address
    logic [31:0]           wdata_reg;          // Captured write data
    logic [3:0]            wstrb_reg;          // Captured strobes

    // Decoded events
    logic       write_fire;                    // Write executes this cycle
    logic       read_fire;                     // Read address taken
    logic       wr_status;                     // Write to status register
    logic       wr_modulo;                     // Write to modulo register
    logic       wr_clock;                      // Write to clock register
    logic       clear_count;                   // Counter-clear request
    logic       source_edge;                   // Selected source edge
    logic       tick;                          // Prescaler output tick
    logic       run;                           // Counter may advance
    logic       at_limit;                      // Count at wrap point
    logic       overflow;                      // Wrap this cycle
    logic       reset_state;                   // Return to reset state
    logic [7:0] div_mask;                      // Prescaler terminal mask
    logic [7:0] status_value;                  // Status read value
    logic [7:0] read_value;                    // Selected read value
    logic       read_ok;                       // Read address mapped
    logic       write_ok;                      // Write address mapped

    // Handshake outputs: take each channel once until response
    // Reads and writes are independent
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign read_fire     = s_axi_arvalid && s_axi_arready;
    assign write_fire    = aw_held_reg && w_held_reg && !s_axi_bvalid;

    // Write decode, lane 0 carries the 8-bit register
    // Upper lanes are ignored
    assign wr_status = write_fire && wstrb_reg[0]
                       && (awaddr_reg == STATUS_CONTROL_OFFSET);    // R16
    assign wr_clock  = write_fire && wstrb_reg[0]
                       && (awaddr_reg == CLOCK_CONFIG_OFFSET);      // R16
    assign wr_modulo = write_fire && wstrb_reg[0]
                       && (awaddr_reg == MODULO_LIMIT_OFFSET);      // R16
    assign write_ok  = (awaddr_reg == STATUS_CONTROL_OFFSET)
                       || (awaddr_reg == CLOCK_CONFIG_OFFSET)
                       || (awaddr_reg == COUNT_VALUE_OFFSET)
                       || (awaddr_reg == MODULO_LIMIT_OFFSET);
    assign clear_count = (wr_status && wdata_reg[COUNTER_CLEAR_BIT])
                         || wr_modulo;                               // R17

    // Deep stop wake or stop exit by reset restores reset state
    // Held each cycle the mode asks
    assign reset_state = power_state.deep_stop_wake
                         || power_state.stop_reset_exit;            // R12

    // Counting allowed: not halted, not stopped, not in debug
    // Wait mode does not freeze
    assign run = !halt_reg && !power_state.stop_mode            // R18 R11 R13
                 && !power_state.debug_active;                      // R14 R9

    // Source edge selection by clock-select code
    // Pin edges arrive 2 cycles late
    always_comb begin
        case (mt_source_type'(clock_select_reg))                    // R20
            MT_SRC_BUS:      source_edge = 1'b1;                    // R3
            MT_SRC_FIXED:    source_edge = fixed_sync_reg[1]
                                           && !fixed_last_reg;      // R3
            MT_SRC_PIN_FALL: source_edge = !pin_sync_reg[1]
                                           && pin_last_reg;         // R5
            MT_SRC_PIN_RISE: source_edge = pin_sync_reg[1]
                                           && !pin_last_reg;        // R5
            default:         source_edge = 1'b1;                    // R20
        endcase
    end

    // Prescaler terminal mask: codes above eight saturate
    // Divide N: tick per Nth edge
    always_comb begin
        if (prescale_reg > PRESCALE_MAX_CODE) begin
            div_mask = 8'hff;                                       // R21
        end else begin
            div_mask = 8'((9'h001 << prescale_reg) - 9'h001);       // R4
        end
    end

    // A tick when the prescaler reaches its terminal count
    assign tick = run && source_edge
                  && ((prescaler_reg & div_mask) == div_mask);      // R4

    // Wrap point: modulo limit, or full range when limit is zero
    assign at_limit = (modulo_reg == MODULO_RESET_VALUE)
                      ? (count_reg == COUNT_FULL_VALUE)
                      : (count_reg == modulo_reg);                  // R23 R1
    assign overflow = tick && at_limit;

    // Interrupt request; also usable as wake from wait
    assign overflow_irq = flag_reg && irq_enable_reg;               // R23 R2 R9

    // Pin synchroniser; only the second stage is read
    // First stage may be metastable
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_sync_reg <= 2'b00;
            pin_last_reg <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], ext_timer_clock_pin}; // R7 R6
            pin_last_reg <= pin_sync_reg[1];
        end
    end

    // Fixed-frequency clock synchroniser
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fixed_sync_reg <= 2'b00;
            fixed_last_reg <= 1'b0;
        end else begin
            fixed_sync_reg <= {fixed_sync_reg[0], fixed_freq_clock};
            fixed_last_reg <= fixed_sync_reg[1];
        end
    end

    // Prescaler counter, advances on each selected source edge
    // Cleared with the count
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prescaler_reg <= 8'h00;
        end else if (reset_state || clear_count) begin
            prescaler_reg <= 8'h00;
        end else if (run && source_edge) begin
            prescaler_reg <= prescaler_reg + 8'h01;                 // R4
        end
    end

    // Up-counter with modulo wrap and clear
    // Clear beats counting
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_reg <= COUNT_RESET_VALUE;
        end else if (reset_state || clear_count) begin
            count_reg <= COUNT_RESET_VALUE;                         // R17 R15
        end else if (overflow) begin
            count_reg <= COUNT_RESET_VALUE;                         // R1
        end else if (tick) begin
            count_reg <= count_reg + 8'h01;                         // R1
        end
    end

    // Modulo limit register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            modulo_reg <= MODULO_RESET_VALUE;
        end else if (reset_state) begin
            modulo_reg <= MODULO_RESET_VALUE;                       // R12
        end else if (wr_modulo) begin
            modulo_reg <= wdata_reg[7:0];
        end
    end

    // Overflow flag: set wins over clear
    // Cleared by read then zero write, or by a count clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flag_reg <= 1'b0;
        end else if (reset_state) begin
            flag_reg <= 1'b0;
        end else if (overflow) begin
            flag_reg <= 1'b1;                                       // R19
        end else if (clear_count) begin
            flag_reg <= 1'b0;                                       // R19
        end else if (wr_status && flag_seen_reg
                     && !wdata_reg[OVERFLOW_FLAG_BIT]) begin
            flag_reg <= 1'b0;                                       // R19
        end
    end

    // Arms the flag clear when status is read with the flag set
    // Any status write disarms
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flag_seen_reg <= 1'b0;
        end else if (reset_state || !flag_reg || wr_status) begin
            flag_seen_reg <= 1'b0;
        end else if (read_fire
                     && s_axi_araddr == STATUS_CONTROL_OFFSET) begin
            flag_seen_reg <= 1'b1;                                  // R19
        end
    end

    // Control bits: halt set and enable cleared at reset
    // Halted until software starts
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_enable_reg <= 1'b0;                                 // R22
            halt_reg       <= 1'b1;                                 // R22
        end else if (reset_state) begin
            irq_enable_reg <= 1'b0;                                 // R12
            halt_reg       <= 1'b1;                                 // R12
        end else if (wr_status) begin
            irq_enable_reg <= wdata_reg[OVERFLOW_IRQ_EN_BIT];       // R2
            halt_reg       <= wdata_reg[COUNTER_HALT_BIT];          // R18
        end
    end

    // Clock configuration register
    // Changes keep the count
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            clock_select_reg <= CLOCK_SELECT_RESET;
            prescale_reg     <= PRESCALE_RESET;
        end else if (reset_state) begin
            clock_select_reg <= CLOCK_SELECT_RESET;
            prescale_reg     <= PRESCALE_RESET;
        end else if (wr_clock) begin
            clock_select_reg <= wdata_reg[CLOCK_SELECT_LSB +: 2];   // R3
            prescale_reg     <= wdata_reg[PRESCALE_LSB +: 4];       // R21
        end
    end

    // Write channel capture
    // Address and data in any order
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end else if (write_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end else if (write_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Write response
    // Unmapped: slave error
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= write_ok ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read value mux; clear bit and unused bits read zero
    assign status_value = {flag_reg, irq_enable_reg, 1'b0,
                           halt_reg, 4'h0};
    always_comb begin
        read_ok = 1'b1;
        case (s_axi_araddr)
            STATUS_CONTROL_OFFSET: read_value = status_value;
            CLOCK_CONFIG_OFFSET:   read_value = {2'b00, clock_select_reg,
                                                 prescale_reg};
            COUNT_VALUE_OFFSET:    read_value = count_reg;
            MODULO_LIMIT_OFFSET:   read_value = modulo_reg;
            default: begin
                read_value = 8'h00;
                read_ok    = 1'b0;
            end
        endcase
    end

    // Read data channel
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= AXI_RESP_OKAY;
        end else if (read_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, read_value};
            s_axi_rresp  <= read_ok ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// >>> testbench/mt_timer_checker.sv
// Checker of the timer ports
module mt_timer_checker
    import mt_pkg::*;
(
    // Clock and reset
    input wire logic         clock,
    input wire logic         resetn,
    // Write channels
    input wire logic         s_axi_awvalid,
    input wire logic         s_axi_awready,
    input wire logic         s_axi_wvalid,
    input wire logic         s_axi_wready,
    input wire logic [1:0]   s_axi_bresp,
    input wire logic         s_axi_bvalid,
    input wire logic         s_axi_bready,
    // Read channels
    input wire logic [3:0]   s_axi_araddr,
    input wire logic         s_axi_arvalid,
    input wire logic         s_axi_arready,
    input wire logic [31:0]  s_axi_rdata,
    input wire logic [1:0]   s_axi_rresp,
    input wire logic         s_axi_rvalid,
    input wire logic         s_axi_rready,
    // Mode and interrupt
    input wire mt_power_type power_state,
    input wire logic         overflow_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // Answer two edges after both are taken
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer missing");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer missing");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_busy_refuse: assert property ((s_axi_bvalid |-> !s_axi_awready
        && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready))
        else $error("taken while busy");
    a_upper_zero: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == AXI_RESP_SLVERR
        && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    a_deep_stop_irq: assert property (power_state.deep_stop_wake
        |=> !overflow_irq) else $error("interrupt after stop wake");
    a_frozen_irq: assert property ($rose(overflow_irq)
        |-> $rose(s_axi_bvalid) || (!$past(power_state.stop_mode)
        && !$past(power_state.debug_active)))
        else $error("overflow while frozen");
    // Main scenarios reached
    c_unmapped: cover property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[1:0] != 2'h0);
    c_irq: cover property ($rose(overflow_irq));
    c_debug_write: cover property (power_state.debug_active && s_axi_bvalid);
endmodule

bind mt_timer mt_timer_checker u_mt_timer_checker (.*);

// >>> testbench/mt_pin_source.sv
// Model of the external clock source that drives the timer pin
module mt_pin_source
#(
    parameter int HALF_CYCLES = 4
) (
    // Bus clock that paces the pin
    input  wire logic clock,
    // Pin drive
    input  wire logic enable,
    output      logic pin
);
    timeunit 1ns;
    timeprecision 100ps;
    int count = 0;
    initial pin = 1'b0;
    // Toggle every HALF_CYCLES, below bus/4
    always @(posedge clock) begin
        if (enable) begin
            count <= (count + 1) % HALF_CYCLES;
            if (count == HALF_CYCLES - 1) pin <= ~pin;
        end
    end
endmodule

// >>> testbench/mt_timer_test.sv
// Testbench of the timer
module mt_timer_test import mt_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, resetn, fixed_freq_clock, pin_enable, pin, irq;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    mt_power_type power_state;
    int err_count = 0;
    int checked = 0;
    logic [7:0] d, c1, c2;
    mt_timer u_mt_timer (.clock, .resetn,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fixed_freq_clock,
        .ext_timer_clock_pin(pin), .power_state, .overflow_irq(irq));
    mt_pin_source u_mt_pin_source (.clock, .enable(pin_enable), .pin);
    // Bus and fixed clocks
    always #25 clock = ~clock;
    always begin
        repeat (4) @(posedge clock);
        fixed_freq_clock <= ~fixed_freq_clock;
    end
    task automatic chk(input string name, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One register write
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        int n = 0;
        @(posedge clock);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        chk("bresp", {bvalid, bresp}, {1'b1, AXI_RESP_OKAY});
    endtask
    // One register read
    task automatic rd(input logic [3:0] a, output logic [7:0] v,
                      input logic [1:0] resp = AXI_RESP_OKAY);
        int n = 0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        rready <= 1'b0;
        v = rdata[7:0];
        chk("rresp", {rvalid, rresp}, {1'b1, resp});
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e,
                        input string name);
        logic [7:0] v;
        rd(a, v);
        chk(name, v, e);
    endtask
    // Run w cycles from zero, read count
    task automatic run_count(input logic [7:0] cfg, input int w);
        wr(CLOCK_CONFIG_OFFSET, cfg);
        wr(STATUS_CONTROL_OFFSET, 8'h20);
        repeat (w) @(posedge clock);
        wr(STATUS_CONTROL_OFFSET, 8'h10);
        rd(COUNT_VALUE_OFFSET, d);
    endtask
    task automatic t_reset();
        rchk(STATUS_CONTROL_OFFSET, 8'h10, "status");
        rchk(CLOCK_CONFIG_OFFSET, 8'h00, "clock cfg");
        rchk(MODULO_LIMIT_OFFSET, 8'h00, "modulo");
        rd(4'h2, d, AXI_RESP_SLVERR);
        chk("unmapped", d, 8'h00);
        wr(COUNT_VALUE_OFFSET, 8'h77);
        rchk(COUNT_VALUE_OFFSET, 8'h00, "count");
        chk("irq", irq, 1'b0);
    endtask
    task automatic t_flag();
        wr(MODULO_LIMIT_OFFSET, 8'h03);
        wr(STATUS_CONTROL_OFFSET, 8'h40);
        repeat (12) @(posedge clock);
        wr(STATUS_CONTROL_OFFSET, 8'h50);
        rchk(STATUS_CONTROL_OFFSET, 8'hd0, "flag set");
        chk("irq on", irq, 1'b1);
        rd(COUNT_VALUE_OFFSET, c1);
        chk("limit", c1 <= 8'h03, 1'b1);
        repeat (10) @(posedge clock);
        rchk(COUNT_VALUE_OFFSET, c1, "halted");
        wr(STATUS_CONTROL_OFFSET, 8'h50);
        rchk(STATUS_CONTROL_OFFSET, 8'h50, "flag cleared");
        chk("irq off", irq, 1'b0);
        for (int i = 0; i < 2; i++) begin
            wr(STATUS_CONTROL_OFFSET, 8'h40);
            repeat (12) @(posedge clock);
            wr(STATUS_CONTROL_OFFSET, 8'h50);
            if (i == 0) wr(MODULO_LIMIT_OFFSET, 8'h03);
            else wr(STATUS_CONTROL_OFFSET, 8'h70);
            rchk(STATUS_CONTROL_OFFSET, 8'h50, "flag by write");
        end
        rchk(COUNT_VALUE_OFFSET, 8'h00, "cleared");
        wr(MODULO_LIMIT_OFFSET, 8'h00);
    endtask
    task automatic t_sources();
        pin_enable <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            run_count({2'b00, s[1:0], 4'h0}, 160);
            c1 = (s == 0) ? 8'd160 : 8'd20;
            chk("source", d >= c1 - 2 && d <= c1 + 6, 1'b1);
            rchk(CLOCK_CONFIG_OFFSET, {2'b00, s[1:0], 4'h0}, "cfg");
        end
        pin_enable <= 1'b0;
    endtask
    task automatic t_prescale();
        for (int p = 0; p < 16; p++) begin
            run_count({4'h0, p[3:0]}, 20 << ((p > 8) ? 8 : p));
            chk("prescale", d >= 8'd19 && d <= 8'd24, 1'b1);
        end
    endtask
    task automatic t_modes();
        int bits[3] = '{4, 3, 0};
        run_count(8'h00, 1);
        wr(STATUS_CONTROL_OFFSET, 8'h00);
        foreach (bits[k]) begin
            power_state[bits[k]] <= 1'b1;
            rd(COUNT_VALUE_OFFSET, c1);
            repeat (20) @(posedge clock);
            rd(COUNT_VALUE_OFFSET, c2);
            if (k == 0) chk("wait runs", 8'(c2 - c1) >= 15, 1'b1);
            else chk("frozen", c2, c1);
            if (k == 2) begin
                wr(STATUS_CONTROL_OFFSET, 8'h20);
                rd(COUNT_VALUE_OFFSET, c2);
                chk("debug clear", c2, 8'h00);
            end
            power_state[bits[k]] <= 1'b0;
            repeat (20) @(posedge clock);
            rd(COUNT_VALUE_OFFSET, c1);
            chk("resumes", 8'(c1 - c2) >= 15, 1'b1);
        end
        for (int b = 1; b < 3; b++) begin
            wr(MODULO_LIMIT_OFFSET, 8'h05);
            wr(STATUS_CONTROL_OFFSET, 8'h40);
            power_state[b] <= 1'b1;
            @(posedge clock);
            power_state[b] <= 1'b0;
            rchk(STATUS_CONTROL_OFFSET, 8'h10, "wake status");
            rchk(MODULO_LIMIT_OFFSET, 8'h00, "wake modulo");
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial begin
        #(90000 * 50);
        err_count++;
        end_of_test();
    end
    initial begin
        {clock, resetn, fixed_freq_clock, pin_enable} = 4'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = {8'h00, 32'h0, 4'hf};
        power_state = '0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_flag();
        t_sources();
        t_prescale();
        t_modes();
        end_of_test();
    end
endmodule
